// file: common/drf_cfg.svh
// Constants for the dual bank CPU register file
`ifndef DRF_CFG_SVH
`define DRF_CFG_SVH
`define DRF_GP_NUM 6
`define DRF_PAIR_NUM 3
`define DRF_BYTE_RST 8'h00
`define DRF_WORD_RST 16'h0000
`define DRF_STACK_RST 16'hFFFF
`define DRF_REFRESH_LOW_MSB 6
`define DRF_REFRESH_INC 7'h01
`define DRF_ADDR_BYTE_MSB 15
`define DRF_ADDR_BYTE_LSB 8
`endif

// file: common/drf_pkg.sv
// Types for the dual bank CPU register file
package drf_pkg;
    // Byte register selector within a bank
    typedef enum logic [2:0] {
        DRF_GP_B0 = 3'b000,
        DRF_GP_B1 = 3'b001,
        DRF_GP_B2 = 3'b010,
        DRF_GP_B3 = 3'b011,
        DRF_GP_B4 = 3'b100,
        DRF_GP_B5 = 3'b101
    } drf_gp_sel_t;
    // Pair selector, first byte high, second low
    typedef enum logic [1:0] {
        DRF_PAIR_01 = 2'b00,
        DRF_PAIR_23 = 2'b01,
        DRF_PAIR_45 = 2'b10
    } drf_pair_sel_t;
    // Dedicated 16-bit word selector
    typedef enum logic [1:0] {
        DRF_W_IDX1 = 2'b00,
        DRF_W_IDX2 = 2'b01,
        DRF_W_STACK = 2'b10,
        DRF_W_FETCH = 2'b11
    } drf_word_sel_t;
endpackage

// file: rtl/drf_bank.sv
// One bank: accumulator, flags, six general purpose bytes
`timescale 1ns/100ps
`include "drf_cfg.svh"
module drf_bank
    import drf_pkg::*;
(
    input wire logic mclk, // System clock
    input wire logic nrst, // Async reset, active low
    input wire logic acc_we, // Accumulator write
    input wire logic [7:0] acc_wdata, // Accumulator data
    input wire logic flg_we, // Flag write
    input wire logic [7:0] flg_wdata, // Flag data
    input wire logic [5:0] gp_we, // Per byte write enables
    input wire logic [47:0] gp_wdata, // Per byte write data
    output logic [7:0] acc, // Accumulator value
    output logic [7:0] flg, // Flag value
    output logic [47:0] gp // All six bytes, byte 0 lowest
);
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            acc <= `DRF_BYTE_RST;
        end else if (acc_we) begin
            acc <= acc_wdata;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            flg <= `DRF_BYTE_RST;
        end else if (flg_we) begin
            flg <= flg_wdata;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < `DRF_GP_NUM; gi++) begin : g_gp
            always_ff @(posedge mclk or negedge nrst) begin
                if (!nrst) begin
                    gp[gi*8 +: 8] <= `DRF_BYTE_RST;
                end else if (gp_we[gi]) begin
                    gp[gi*8 +: 8] <= gp_wdata[gi*8 +: 8];
                end
            end
        end
    endgenerate
endmodule // drf_bank

// file: rtl/drf_regfile.sv
// Dual bank programmer visible register file of an 8-bit CPU
// What this block does
// - Six general bytes per bank, each alone or in fixed 16-bit pairs.
// - Main and alternate banks; exchange picks visible one, other kept.
// - Each bank has own accumulator, flags and six general bytes.
// - Accumulator is 8 bits, holds operand or receives result.
// - Bytes 0 and 1 form one 16-bit pair.
// - Bytes 2 and 3 form one 16-bit pair.
// - Six dedicated registers: vector base, refresh, two index, stack, fetch.
// - Two interrupt status flip-flops plus two interrupt mode flip-flops.
// - Bytes 4 and 5 form one 16-bit pair.
// - First named byte of a pair is high, second is low.
// - Refresh 8 bits, low seven auto increment, all eight on address.
// - Vector base supplies upper eight address bits for vectored interrupts.
//
// Our own choices: the address map and strobed register access.
`timescale 1ns/100ps
`include "drf_cfg.svh"
module drf_regfile
    import drf_pkg::*;
(
    input wire logic mclk, // 50 MHz CPU clock
    input wire logic nrst, // Async reset, active low
    input wire logic xchg_af, // Pulse: swap accumulator/flag bank
    input wire logic xchg_gp, // Pulse: swap general register bank
    input wire logic acc_we, // Visible accumulator write
    input wire logic [7:0] acc_wdata, // Accumulator write data
    input wire logic flg_we, // Visible flag write
    input wire logic [7:0] flg_wdata, // Flag write data
    input wire logic byte_we, // Visible general byte write
    input wire drf_gp_sel_t byte_wsel, // Byte write select
    input wire logic [7:0] byte_wdata, // Byte write data
    input wire logic pair_we, // Visible pair write
    input wire drf_pair_sel_t pair_wsel, // Pair write select
    input wire logic [15:0] pair_wdata, // Pair write data
    input wire drf_gp_sel_t byte_rsel, // Byte read select
    input wire drf_pair_sel_t pair_rsel, // Pair read select
    input wire logic word_we, // Dedicated word write
    input wire drf_word_sel_t word_wsel, // Word write select
    input wire logic [15:0] word_wdata, // Word write data
    input wire drf_word_sel_t word_rsel, // Word read select
    input wire logic vec_we, // Vector base write
    input wire logic [7:0] vec_wdata, // Vector base data
    input wire logic rfsh_we, // Refresh counter write
    input wire logic [7:0] rfsh_wdata, // Refresh write data
    input wire logic rfsh_inc, // Pulse: fetch done, bump refresh
    input wire logic [7:0] vec_low, // Vector byte from peripheral
    input wire logic iff_we, // Write both status flip-flops
    input wire logic iff_wdata, // Value for both
    input wire logic iff_nmi, // Accept non-maskable: save then clear
    input wire logic iff_restore, // Copy saved back to accept
    input wire logic im_we, // Interrupt mode write
    input wire logic [1:0] im_wdata, // Mode value, bit1 hi bit0 lo
    output logic [7:0] acc, // Visible accumulator
    output logic [7:0] flg, // Visible flags
    output logic [7:0] byte_rdata, // Selected visible byte
    output logic [15:0] pair_rdata, // Selected visible pair
    output logic [15:0] word_rdata, // Selected dedicated word
    output logic [7:0] vec_base, // Vector base register
    output logic [7:0] rfsh_cnt, // Refresh counter
    output logic [15:0] rfsh_addr, // Refresh address bus value
    output logic [15:0] vec_addr, // Vectored interrupt table address
    output logic int_accept_flag, // Maskable interrupt enabled
    output logic int_saved_flag, // Saved enable copy
    output logic int_mode_bit_lo, // Mode flip-flop low
    output logic int_mode_bit_hi, // Mode flip-flop high
    output logic af_bank, // Acc/flag bank in use
    output logic gp_bank // General bank in use
);
    logic af_bank_r;
    logic gp_bank_r;
    logic [15:0] first_index_reg_r;
    logic [15:0] second_index_reg_r;
    logic [15:0] stack_top_ptr_r;
    logic [15:0] next_fetch_addr_r;
    logic [7:0] vec_base_r;
    logic [7:0] rfsh_r;
    logic [6:0] rfsh_low_nxt;
    logic int_accept_flag_r;
    logic int_saved_flag_r;
    logic [1:0] im_r;
    logic [7:0] acc_b [2];
    logic [7:0] flg_b [2];
    logic [47:0] gp_b [2];
    logic [47:0] gp_vis;
    logic [5:0] gp_we_vis;
    logic [47:0] gp_wd;

    // Byte write enable vector for one pair index
    function automatic logic [5:0] pair_mask(input drf_pair_sel_t p);
        pair_mask = 6'h03 << {p, 1'b0};
    endfunction

    // Bank flags only toggle: the swap renames, no data moves
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            af_bank_r <= 1'b0;
            gp_bank_r <= 1'b0;
        end else begin
            af_bank_r <= af_bank_r ^ xchg_af;
            gp_bank_r <= gp_bank_r ^ xchg_gp;
        end
    end

    assign gp_we_vis = (byte_we ? (6'h01 << byte_wsel) : 6'h00) |
                       (pair_we ? pair_mask(pair_wsel) : 6'h00);

    // Pair high byte is the lower numbered byte
    genvar pi;
    generate
        for (pi = 0; pi < `DRF_PAIR_NUM; pi++) begin : g_wd
            wire pair_hit = pair_we && (pair_wsel == drf_pair_sel_t'(pi));
            assign gp_wd[pi*16 +: 8] = pair_hit ? pair_wdata[15:8]
                                                : byte_wdata;
            assign gp_wd[pi*16+8 +: 8] = pair_hit ? pair_wdata[7:0]
                                                  : byte_wdata;
        end
    endgenerate

    // Writes only reach the visible bank, so the hidden one is untouched
    genvar bi;
    generate
        for (bi = 0; bi < 2; bi++) begin : g_bank
            wire af_sel = (af_bank_r == bi[0]);
            wire gp_sel = (gp_bank_r == bi[0]);
            drf_bank u_bank (
                .mclk(mclk),
                .nrst(nrst),
                .acc_we(acc_we && af_sel),
                .acc_wdata(acc_wdata),
                .flg_we(flg_we && af_sel),
                .flg_wdata(flg_wdata),
                .gp_we(gp_sel ? gp_we_vis : 6'h00),
                .gp_wdata(gp_wd),
                .acc(acc_b[bi]),
                .flg(flg_b[bi]),
                .gp(gp_b[bi])
            );
        end
    endgenerate

    assign acc = acc_b[af_bank_r];
    assign flg = flg_b[af_bank_r];
    assign gp_vis = gp_b[gp_bank_r];
    assign byte_rdata = gp_vis[byte_rsel*8 +: 8];
    assign pair_rdata = {gp_vis[pair_rsel*16 +: 8],
                         gp_vis[pair_rsel*16+8 +: 8]};
    assign af_bank = af_bank_r;
    assign gp_bank = gp_bank_r;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            first_index_reg_r <= `DRF_WORD_RST;
            second_index_reg_r <= `DRF_WORD_RST;
            stack_top_ptr_r <= `DRF_STACK_RST;
            next_fetch_addr_r <= `DRF_WORD_RST;
        end else if (word_we) begin
            unique case (word_wsel)
                DRF_W_IDX1: first_index_reg_r <= word_wdata;
                DRF_W_IDX2: second_index_reg_r <= word_wdata;
                DRF_W_STACK: stack_top_ptr_r <= word_wdata;
                DRF_W_FETCH: next_fetch_addr_r <= word_wdata;
            endcase
        end
    end

    always_comb begin
        unique case (word_rsel)
            DRF_W_IDX1: word_rdata = first_index_reg_r;
            DRF_W_IDX2: word_rdata = second_index_reg_r;
            DRF_W_STACK: word_rdata = stack_top_ptr_r;
            DRF_W_FETCH: word_rdata = next_fetch_addr_r;
        endcase
    end

    // Bit 7 of refresh is software-only; increment wraps the low seven
    assign rfsh_low_nxt = rfsh_r[`DRF_REFRESH_LOW_MSB:0] + `DRF_REFRESH_INC;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            vec_base_r <= `DRF_BYTE_RST;
            rfsh_r <= `DRF_BYTE_RST;
        end else begin
            if (vec_we) begin
                vec_base_r <= vec_wdata;
            end
            // Software write wins over the fetch increment
            if (rfsh_we) begin
                rfsh_r <= rfsh_wdata;
            end else if (rfsh_inc) begin
                rfsh_r <= {rfsh_r[7], rfsh_low_nxt};
            end
        end
    end

    assign vec_base = vec_base_r;
    assign rfsh_cnt = rfsh_r;
    assign rfsh_addr = {vec_base_r, rfsh_r};
    assign vec_addr = {vec_base_r, vec_low};

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            int_accept_flag_r <= 1'b0;
            int_saved_flag_r <= 1'b0;
            im_r <= 2'b00;
        end else begin
            if (iff_nmi) begin
                int_accept_flag_r <= 1'b0;
                int_saved_flag_r <= int_accept_flag_r;
            end else if (iff_we) begin
                int_accept_flag_r <= iff_wdata;
                int_saved_flag_r <= iff_wdata;
            end else if (iff_restore) begin
                int_accept_flag_r <= int_saved_flag_r;
            end
            if (im_we) begin
                im_r <= im_wdata;
            end
        end
    end

    assign int_accept_flag = int_accept_flag_r;
    assign int_saved_flag = int_saved_flag_r;
    assign int_mode_bit_lo = im_r[0];
    assign int_mode_bit_hi = im_r[1];
endmodule // drf_regfile

// file: verification/drf_regfile_monitor.sv
// Port-level assertions for the dual bank register file
`timescale 1ns/100ps
module drf_regfile_monitor
    import drf_pkg::*;
(
    input wire logic mclk, // Clock
    input wire logic nrst, // Reset, active low
    input wire logic xchg_af, xchg_gp, acc_we, pair_we, // Strobes
    input wire logic rfsh_we, rfsh_inc, iff_nmi, // Strobes
    input wire logic [7:0] acc_wdata, vec_low, acc, vec_base, rfsh_cnt, // Bytes
    input wire drf_pair_sel_t pair_wsel, pair_rsel, // Pair selects
    input wire logic [15:0] pair_wdata, pair_rdata, rfsh_addr, vec_addr, // Words
    input wire logic int_accept_flag, int_saved_flag, af_bank, gp_bank // Flops
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    sequence s_pair_wr;
        pair_we && !xchg_gp ##1 pair_rsel == $past(pair_wsel);
    endsequence
    sequence s_swap2;
        (xchg_af && !acc_we) ##1 (xchg_af && !acc_we);
    endsequence

    property p_rfsh_addr;
        rfsh_addr == {vec_base, rfsh_cnt};
    endproperty
    property p_vec_addr;
        vec_addr == {vec_base, vec_low};
    endproperty
    // Bit 7 is never carried into
    property p_rfsh_inc;
        rfsh_inc && !rfsh_we |=> rfsh_cnt == (($past(rfsh_cnt) & 8'h80)
            | (($past(rfsh_cnt) + 8'h01) & 8'h7F));
    endproperty
    property p_af_swap;
        1'b1 |=> af_bank == ($past(af_bank) ^ $past(xchg_af));
    endproperty
    property p_gp_swap;
        1'b1 |=> gp_bank == ($past(gp_bank) ^ $past(xchg_gp));
    endproperty
    property p_acc_wr;
        acc_we && !xchg_af |=> acc == $past(acc_wdata);
    endproperty
    property p_nmi;
        iff_nmi |=> !int_accept_flag && int_saved_flag == $past(int_accept_flag);
    endproperty
    property p_pair_wr;
        s_pair_wr |-> pair_rdata == $past(pair_wdata);
    endproperty
    // Two swaps in a row must bring back the untouched value
    property p_swap2;
        s_swap2 |=> acc == $past(acc, 2);
    endproperty

    a_rfsh_addr: assert property (p_rfsh_addr) else $error("refresh address");
    a_vec_addr: assert property (p_vec_addr) else $error("vector address");
    a_rfsh_inc: assert property (p_rfsh_inc) else $error("refresh step");
    a_af_swap: assert property (p_af_swap) else $error("acc bank toggle");
    a_gp_swap: assert property (p_gp_swap) else $error("gp bank toggle");
    a_acc_wr: assert property (p_acc_wr) else $error("acc write");
    a_nmi: assert property (p_nmi) else $error("nmi flag save");
    a_pair_wr: assert property (p_pair_wr) else $error("pair write");
    a_swap2: assert property (p_swap2) else $error("bank copy seen");
endmodule // drf_regfile_monitor

bind drf_regfile drf_regfile_monitor u_mon (.*);

// file: verification/drf_regfile_test.sv
// Self-checking bench for the dual bank register file
`timescale 1ns/100ps
module drf_regfile_test import drf_pkg::*;;
    logic mclk, nrst, xchg_af, xchg_gp, acc_we, flg_we, byte_we, pair_we;
    logic word_we, vec_we, rfsh_we, rfsh_inc, iff_we, iff_wdata, iff_nmi;
    logic iff_restore, im_we, int_accept_flag, int_saved_flag;
    logic int_mode_bit_lo, int_mode_bit_hi, af_bank, gp_bank;
    logic [7:0] acc_wdata, flg_wdata, byte_wdata, vec_wdata, rfsh_wdata;
    logic [7:0] vec_low, acc, flg, byte_rdata, vec_base, rfsh_cnt;
    logic [15:0] pair_wdata, word_wdata, pair_rdata, word_rdata;
    logic [15:0] rfsh_addr, vec_addr;
    logic [1:0] im_wdata;
    drf_gp_sel_t byte_wsel, byte_rsel;
    drf_pair_sel_t pair_wsel, pair_rsel;
    drf_word_sel_t word_wsel, word_rsel;
    int err_total, cmp_count;

    drf_regfile u_dut (.*);

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    task clr;
        {xchg_af, xchg_gp, acc_we, flg_we, byte_we, pair_we, word_we, vec_we,
            rfsh_we, rfsh_inc, iff_we, iff_nmi, iff_restore, im_we} <= '0;
    endtask

    task chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task close_out;
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task t_reset;
        for (int i = 0; i < 4; i++) begin
            @(posedge mclk);
            word_rsel <= drf_word_sel_t'(i);
            #1;
            chk(word_rdata, (i == 2) ? 16'hFFFF : 16'h0000);
        end
        chk({acc, flg}, 16'h0000);
        chk({6'h00, af_bank, gp_bank, rfsh_cnt}, 16'h0000);
        $display("test reset done");
    endtask

    task t_pairs;
        for (int k = 0; k < 3; k++) begin
            @(posedge mclk);
            pair_we <= 1'b1;
            pair_wsel <= drf_pair_sel_t'(k);
            pair_wdata <= 16'hA1B0 + 16'(k);
            @(posedge mclk);
            clr;
            pair_rsel <= drf_pair_sel_t'(k);
            byte_rsel <= drf_gp_sel_t'(2 * k);
            #1;
            chk(pair_rdata, 16'hA1B0 + 16'(k));
            chk(byte_rdata, 8'hA1);
            @(posedge mclk);
            byte_we <= 1'b1;
            byte_wsel <= drf_gp_sel_t'(2 * k + 1);
            byte_wdata <= 8'h5A;
            byte_rsel <= drf_gp_sel_t'(2 * k + 1);
            @(posedge mclk);
            clr;
            #1;
            chk(pair_rdata, 16'hA15A);
        end
        $display("test pairs done");
    endtask

    task t_banks;
        @(posedge mclk);
        {acc_we, flg_we, acc_wdata, flg_wdata} <= {2'b11, 16'h3CC3};
        pair_rsel <= DRF_PAIR_01;
        pair_wsel <= DRF_PAIR_01;
        @(posedge mclk);
        {acc_we, flg_we, xchg_gp} <= 3'b001;
        #1;
        chk({acc, flg}, 16'h3CC3);
        @(posedge mclk);
        {xchg_gp, pair_we, xchg_af, acc_we} <= 4'b0111;
        {pair_wdata, acc_wdata} <= {16'h7777, 8'h11};
        #1;
        chk(pair_rdata, 16'h0000);
        @(posedge mclk);
        clr;
        #1;
        chk(pair_rdata, 16'h7777);
        chk({acc, flg}, 16'h0000);
        @(posedge mclk);
        {xchg_af, xchg_gp} <= 2'b11;
        @(posedge mclk);
        xchg_gp <= 1'b0;
        #1;
        chk(pair_rdata, 16'hA15A);
        chk({acc, flg}, 16'h11C3);
        @(posedge mclk);
        xchg_af <= 1'b0;
        #1;
        chk({acc, flg}, 16'h0000);
        $display("test banks done");
    endtask

    task t_words;
        for (int i = 0; i < 4; i++) begin
            @(posedge mclk);
            word_we <= 1'b1;
            word_wsel <= drf_word_sel_t'(i);
            word_wdata <= 16'h1111 * 16'(i + 1);
        end
        @(posedge mclk);
        word_we <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            @(posedge mclk);
            word_rsel <= drf_word_sel_t'(i);
            #1;
            chk(word_rdata, 16'h1111 * 16'(i + 1));
        end
        $display("test words done");
    endtask

    task t_rfsh;
        @(posedge mclk);
        {vec_we, rfsh_we, vec_wdata, rfsh_wdata} <= {2'b11, 16'h5CFF};
        vec_low <= 8'h2E;
        @(posedge mclk);
        {vec_we, rfsh_we, rfsh_inc} <= 3'b001;
        @(posedge mclk);
        rfsh_inc <= 1'b0;
        #1;
        chk(rfsh_addr, 16'h5C80);
        chk(vec_addr, 16'h5C2E);
        @(posedge mclk);
        {rfsh_we, rfsh_inc, rfsh_wdata} <= {2'b11, 8'h7F};
        @(posedge mclk);
        rfsh_we <= 1'b0;
        #1;
        chk(rfsh_cnt, 8'h7F);
        @(posedge mclk);
        rfsh_inc <= 1'b0;
        #1;
        chk(rfsh_cnt, 8'h00);
        $display("test refresh done");
    endtask

    task t_iff;
        for (int m = 0; m < 4; m++) begin
            @(posedge mclk);
            {iff_we, iff_wdata, im_we, im_wdata} <= {3'b111, 2'(m)};
            @(posedge mclk);
            {iff_we, im_we, iff_nmi} <= 3'b001;
            @(posedge mclk);
            {iff_nmi, iff_restore} <= 2'b01;
            #1;
            chk({int_accept_flag, int_saved_flag, int_mode_bit_hi,
                int_mode_bit_lo}, 16'(4 + m));
            @(posedge mclk);
            iff_restore <= 1'b0;
            #1;
            chk({int_accept_flag, int_saved_flag, int_mode_bit_hi,
                int_mode_bit_lo}, 16'(12 + m));
        end
        // Save beats a same-cycle enable write, then a disable clears both
        @(posedge mclk);
        {iff_we, iff_wdata, iff_nmi} <= 3'b111;
        @(posedge mclk);
        {iff_we, iff_wdata, iff_nmi} <= 3'b100;
        #1;
        chk({int_accept_flag, int_saved_flag}, 16'h0001);
        @(posedge mclk);
        iff_we <= 1'b0;
        #1;
        chk({int_accept_flag, int_saved_flag}, 16'h0000);
        $display("test interrupt flops done");
    endtask

    initial begin
        err_total = 0;
        cmp_count = 0;
        nrst <= 1'b0;
        clr;
        {acc_wdata, flg_wdata, byte_wdata, vec_wdata, rfsh_wdata} <= '0;
        {vec_low, pair_wdata, word_wdata, im_wdata, iff_wdata} <= '0;
        {byte_wsel, byte_rsel} <= {DRF_GP_B0, DRF_GP_B0};
        {pair_wsel, pair_rsel} <= {DRF_PAIR_01, DRF_PAIR_01};
        {word_wsel, word_rsel} <= {DRF_W_IDX1, DRF_W_IDX1};
        repeat (8) @(posedge mclk);
        nrst <= 1'b1;
        t_reset;
        t_pairs;
        t_banks;
        t_words;
        t_rfsh;
        t_iff;
        close_out;
    end

    // Cuts a hang short
    initial begin
        repeat (4000) @(posedge mclk);
        err_total++;
        $display("unexpected at %0t got %h exp %h", $time, 1'b0, 1'b1);
        close_out;
    end
endmodule // drf_regfile_test
